/* File: logic/cani_core.sv */
// integration, idle detection and intermission core of a can controller
// with an apb register slave; assumes a frame decoder outside that
// reports crc checks and frame ends and supplies transmit bits
`timescale 1ns/10ps
module cani_core
   import cani_pkg::*;
#(
   parameter int SEG_W = 7,
   parameter int BRP_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rxd,
   output logic txd,
   input wire logic tx_req,
   input wire logic tx_first_bit,
   input wire logic tx_bit,
   output logic tx_bit_next,
   input wire logic pexc,
   input wire logic frame_done,
   input wire logic crc_check,
   input wire logic fd_frame,
   input wire logic [16:0] rx_crc,
   output logic [16:0] crc_fd,
   output logic [14:0] crc_classic,
   output logic bus_idle,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic rx_data
);
`include "cani_regs.svh"

   cani_state_e state_q, state_d;
   logic [31:0] ctrl_q, nbtr_q, prdata_q;
   logic ack_q, crc_err_q, ovr_q;
   logic [BRP_W-1:0] pre_q;
   logic [SEG_W+1:0] q_q;
   logic [3:0] idle_q;
   logic [2:0] bcnt_q;
   logic tx_role_q, first_q, rx_prev_q, txd_q;
   logic [16:0] crc_fd_q;
   logic [14:0] crc_cl_q;

   // apb decode; one wait cycle, registered read data
   wire hit_ctrl = paddr == `CANI_CTRL_OFF;
   wire hit_nbtr = paddr == `CANI_NBTR_OFF;
   wire hit_stat = paddr == `CANI_STAT_OFF;
   wire mapped = hit_ctrl | hit_nbtr | hit_stat;
   wire acc = psel && penable && ack_q;
   wire wr_ctrl = acc && pwrite && hit_ctrl;
   wire wr_nbtr = acc && pwrite && hit_nbtr;
   wire wr_stat = acc && pwrite && hit_stat;
   wire [31:0] stat_v = {22'h0, ovr_q, crc_err_q, 2'h0, state_q};
   wire [31:0] rd_mux = hit_ctrl ? ctrl_q : hit_nbtr ? nbtr_q :
                        hit_stat ? stat_v : 32'h0000_0000;
   assign pready = psel && penable && ack_q;
   assign pslverr = pready && !mapped;
   assign prdata = prdata_q;

   // control fields
   wire init_hold_bit = ctrl_q[`CANI_CTRL_INIT];
   wire protocol_exception_halt_disable = ctrl_q[`CANI_CTRL_HALT_DIS];
   wire edge_filter_enable = ctrl_q[`CANI_CTRL_EFE];
   wire [SEG_W-1:0] seg2_f = nbtr_q[`CANI_NBTR_SEG2_LSB +: SEG_W];
   wire [SEG_W-1:0] seg1_f = nbtr_q[`CANI_NBTR_SEG1_LSB +: SEG_W];
   wire [BRP_W-1:0] brp_f = nbtr_q[`CANI_NBTR_BRP_LSB +: BRP_W];

   // bus side registers; hardware sets of sticky flags win over clears
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         ctrl_q <= `CANI_CTRL_RST;
         nbtr_q <= `CANI_NBTR_RST;
      end else begin
         ack_q <= psel && penable && !ack_q;
         if (psel && !penable) prdata_q <= rd_mux;
         if (wr_ctrl) ctrl_q <= pwdata & 32'h0000_0007;
         // exception halt sets the init bit even against a write
         if (pexc && protocol_exception_halt_disable)
            ctrl_q[`CANI_CTRL_INIT] <= 1'b1;
         if (wr_nbtr) nbtr_q <= pwdata & 32'h00FF_7F7F;
      end
   end

   // time quantum enable from the prescaler
   // >= so a prescaler shrunk mid-count does not wait for a wrap
   wire tq_en = pre_q >= brp_f;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pre_q <= '0;
      else pre_q <= tq_en ? '0 : pre_q + 1'b1;
   end

   // edge filter works only while integrating
   wire filt_on = edge_filter_enable && state_q == CANI_INTEG;
   logic rx_bt;
   cani_edge_filter u_filt (
      .pclk(pclk),
      .presetn(presetn),
      .tq_en(tq_en),
      .filt_on(filt_on),
      .rxd(rxd),
      .rx_bt(rx_bt)
   );

   // bit timing: sync quantum, seg1 of field+1, seg2 of field+1
   wire [SEG_W+1:0] samp_at = {2'b00, seg1_f} + 1'b1;
   wire [SEG_W+1:0] bit_last = samp_at + {2'b00, seg2_f} + 1'b1;
   wire hard_sync = rx_prev_q && !rx_bt && (state_q == CANI_IDLE ||
                    state_q == CANI_INTEG || state_q == CANI_INTERM);
   wire samp = tq_en && q_q == samp_at;
   wire bit_end = tq_en && q_q == bit_last;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_q <= '0;
         rx_prev_q <= 1'b1;
      end else if (tq_en) begin
         rx_prev_q <= rx_bt;
         q_q <= hard_sync ? (SEG_W+2)'(1) :
                (q_q == bit_last ? '0 : q_q + 1'b1);
      end
   end

   // events of the state machine
   wire idle_hit = samp && rx_bt && idle_q == `CANI_IDLE_BITS - 1'b1;
   wire third_dom = samp && !rx_bt && bcnt_q == `CANI_INTERM_BITS - 1'b1;
   wire start_tx3 = state_q == CANI_INTERM && third_dom && tx_req;
   wire sof_rx = state_q == CANI_IDLE && samp && !rx_bt;
   wire sof_tx = state_q == CANI_IDLE && bit_end && tx_req;
   wire sof_evt = sof_rx | sof_tx | start_tx3 |
                  (state_q == CANI_INTERM && third_dom);
   wire crc_bad = crc_check && fd_frame && crc_fd_q != rx_crc;

   // protocol state transitions
   always_comb begin
      state_d = state_q;
      case (state_q)
         CANI_OFF: begin
            if (!init_hold_bit) state_d = CANI_INTEG;
         end
         CANI_INTEG: begin
            if (idle_hit) state_d = CANI_IDLE;
         end
         CANI_IDLE: begin
            if (sof_rx || sof_tx) state_d = CANI_FRAME;
         end
         CANI_FRAME: begin
            if (crc_bad) state_d = CANI_ERRF;
            else if (frame_done) state_d = CANI_INTERM;
         end
         CANI_ERRF: begin
            if (bit_end && bcnt_q == `CANI_ERR_BITS - 1'b1)
               state_d = CANI_INTERM;
         end
         CANI_INTERM: begin
            if (third_dom) state_d = CANI_FRAME;
            else if (bit_end && bcnt_q == `CANI_INTERM_BITS - 1'b1)
               state_d = CANI_IDLE;
         end
         default: state_d = CANI_OFF;
      endcase
      if (init_hold_bit) state_d = CANI_OFF;
      else if (pexc && state_q != CANI_OFF &&
               !protocol_exception_halt_disable)
         state_d = CANI_INTEG;
   end

   // state, idle counter and bit counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= CANI_OFF;
         idle_q <= 4'h0;
         bcnt_q <= 3'h0;
      end else begin
         state_q <= state_d;
         if (state_q != CANI_INTEG) idle_q <= 4'h0;
         else if (samp) idle_q <= rx_bt ? idle_q + 1'b1 : 4'h0;
         if (state_d != state_q) bcnt_q <= 3'h0;
         else if (bit_end) bcnt_q <= bcnt_q + 1'b1;
      end
   end

   // transmit side: sof, first identifier bit, then the decoder's bits
   wire load_bit = bit_end && tx_role_q && state_q == CANI_FRAME;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_role_q <= 1'b0;
         first_q <= 1'b0;
         txd_q <= 1'b1;
      end else begin
         if (sof_tx || start_tx3) begin
            tx_role_q <= 1'b1;
            first_q <= 1'b1;
            txd_q <= !sof_tx; // dominant sof from idle
         end else if (state_q != CANI_FRAME) begin
            tx_role_q <= 1'b0;
            first_q <= 1'b0;
            txd_q <= !(state_q == CANI_ERRF);
         end else if (load_bit) begin
            first_q <= 1'b0;
            txd_q <= first_q ? tx_first_bit : tx_bit;
         end
      end
   end
   assign txd = txd_q;
   assign tx_bit_next = load_bit && !first_q;

   // fd and classic crc, both cleared at frame start and kept apart
   wire fb17 = rx_bt ^ crc_fd_q[16];
   wire fb15 = rx_bt ^ crc_cl_q[14];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crc_fd_q <= `CANI_CRC17_INIT;
         crc_cl_q <= `CANI_CRC15_INIT;
      end else if (sof_evt) begin
         crc_fd_q <= `CANI_CRC17_INIT;
         crc_cl_q <= `CANI_CRC15_INIT;
      end else if (samp && state_q == CANI_FRAME) begin
         crc_fd_q <= {crc_fd_q[15:0], 1'b0} ^ (fb17 ? `CANI_CRC17_POLY : '0);
         crc_cl_q <= {crc_cl_q[13:0], 1'b0} ^ (fb15 ? `CANI_CRC15_POLY : '0);
      end
   end
   assign crc_fd = crc_fd_q;
   assign crc_classic = crc_cl_q;

   // sticky faults, write one to clear; a new event wins
   wire rx_push = samp && state_q == CANI_FRAME;
   logic rx_in_ready;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crc_err_q <= 1'b0;
         ovr_q <= 1'b0;
      end else begin
         crc_err_q <= (state_q == CANI_FRAME && crc_bad) ||
                      (crc_err_q && !(wr_stat && pwdata[`CANI_STAT_CRCERR]));
         ovr_q <= (rx_push && !rx_in_ready) ||
                  (ovr_q && !(wr_stat && pwdata[`CANI_STAT_OVR]));
      end
   end
   assign bus_idle = state_q == CANI_IDLE;

   // received bits towards the frame decoder
   cani_buf2 #(.WIDTH(1)) u_rxbuf (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(rx_push),
      .in_ready(rx_in_ready),
      .in_data(rx_bt),
      .out_valid(rx_valid),
      .out_ready(rx_ready),
      .out_data(rx_data)
   );

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_init_starts_integ: assert property (
      state_q == CANI_OFF && !init_hold_bit && !pexc |=> state_q == CANI_INTEG)
      else $error("no integration after init cleared");
   a_pexc_halted: assert property (
      pexc && protocol_exception_halt_disable && state_q != CANI_OFF
      |=> init_hold_bit ##1 state_q == CANI_OFF)
      else $error("exception with halt did not stop");
   a_idle_after_11: assert property (
      state_q == CANI_INTEG && idle_hit && !init_hold_bit && !pexc
      |=> bus_idle)
      else $error("idle not reached at eleventh recessive bit");
   a_filter_integ_only: assert property (
      state_q != CANI_INTEG |-> rx_bt == rxd)
      else $error("filter active outside integration");
   a_filter_off_raw: assert property (
      !edge_filter_enable |-> rx_bt == rxd)
      else $error("unfiltered path delayed");
   a_crc_reset_sof: assert property (
      sof_evt |=> crc_fd_q == `CANI_CRC17_INIT)
      else $error("fd crc not cleared at frame start");
   a_crc_err_frame: assert property (
      state_q == CANI_FRAME && crc_bad && !init_hold_bit && !pexc
      |=> state_q == CANI_ERRF ##1 !txd)
      else $error("crc mismatch without error frame");
   a_third_bit_tx: assert property (
      start_tx3 && !init_hold_bit && !pexc
      |=> state_q == CANI_FRAME && tx_role_q && first_q)
      else $error("pending transmission not started");
   a_first_id_level: assert property (
      load_bit && first_q |=> txd == $past(tx_first_bit))
      else $error("first identifier bit at wrong level");
   a_seg2_length: assert property (
      samp && !hard_sync |=> q_q == $past(samp_at) + 1'b1)
      else $error("bit timing did not advance into seg2");
   c_reach_idle: cover property (state_q == CANI_INTEG ##1 bus_idle);
   c_third_dom: cover property (start_tx3);
   c_error_frame: cover property (state_q == CANI_ERRF);
   c_rx_stall: cover property (rx_push && !rx_in_ready);
endmodule

/* File: inc/cani_regs.svh */
// register map, field positions, reset values and counts of the
// integration and intermission block; definitions only
`ifndef CANI_REGS_SVH
`define CANI_REGS_SVH
// register byte offsets
`define CANI_CTRL_OFF 12'h000
`define CANI_NBTR_OFF 12'h004
`define CANI_STAT_OFF 12'h008
// control register fields
`define CANI_CTRL_INIT 0
`define CANI_CTRL_HALT_DIS 1
`define CANI_CTRL_EFE 2
`define CANI_CTRL_RST 32'h0000_0001
// nominal bit timing fields: seg2 [6:0], seg1 [14:8], prescaler [23:16]
`define CANI_NBTR_SEG2_LSB 0
`define CANI_NBTR_SEG1_LSB 8
`define CANI_NBTR_BRP_LSB 16
`define CANI_NBTR_RST 32'h0009_0F03
// status register fields
`define CANI_STAT_CRCERR 8
`define CANI_STAT_OVR 9
// bit counts
`define CANI_IDLE_BITS 4'hB
`define CANI_ERR_BITS 3'h6
`define CANI_INTERM_BITS 2'h3
// crc polynomials and start values
`define CANI_CRC15_POLY 15'h4599
`define CANI_CRC15_INIT 15'h0000
`define CANI_CRC17_POLY 17'h1685B
`define CANI_CRC17_INIT 17'h10000
`endif

/* File: inc/cani_pkg.sv */
// types shared by the integration and intermission block
// assumes nothing of its surroundings
package cani_pkg;
   // protocol states, one-hot
   typedef enum logic [5:0] {
      CANI_OFF = 6'h01,
      CANI_INTEG = 6'h02,
      CANI_IDLE = 6'h04,
      CANI_FRAME = 6'h08,
      CANI_ERRF = 6'h10,
      CANI_INTERM = 6'h20
   } cani_state_e;
endpackage

/* File: logic/cani_edge_filter.sv */
// edge filter between the receive pin and the bit timing logic
// assumes tq_en is a one-cycle pulse per time quantum on pclk
`timescale 1ns/10ps
module cani_edge_filter
   import cani_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tq_en,
   input wire logic filt_on,
   input wire logic rxd,
   output logic rx_bt
);
   logic prev_dom_q;
   logic filt_q;
   // a dominant level passes only once seen on two tq strobes in a row
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_dom_q <= 1'b0;
         filt_q <= 1'b1;
      end else if (tq_en) begin
         prev_dom_q <= !rxd;
         filt_q <= rxd | !prev_dom_q;
      end
   end
   // filtered view only while enabled, else the raw pin
   assign rx_bt = filt_on ? filt_q : rxd;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_spike_ignored: assert property (
      $fell(filt_q) |-> $past(prev_dom_q) && !$past(rxd))
      else $error("filter passed a single dominant quantum");
endmodule

/* File: logic/cani_buf2.sv */
// two-entry buffer with valid and ready on both sides
// assumes a single clock; the writer honours in_ready
`timescale 1ns/10ps
module cani_buf2
   import cani_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem_q [2];
   logic rd_q;
   logic wr_q;
   logic [1:0] cnt_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = cnt_q != 2'h2;
   assign out_valid = cnt_q != 2'h0;
   assign out_data = mem_q[rd_q];
   // pointers, fill count and storage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         cnt_q <= 2'h0;
         mem_q[0] <= '0;
         mem_q[1] <= '0;
      end else begin
         if (push) mem_q[wr_q] <= in_data;
         if (push) wr_q <= !wr_q;
         if (pop) rd_q <= !rd_q;
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

/* File: verification/cani_peer.sv */
// peer node on the shared can bus: drives its own level onto the wire
// assumes callers step just after a rising pclk edge
`timescale 1ns/10ps
module cani_peer (
   input wire logic pclk,
   input wire logic txd,
   output logic rxd
);
   logic node_q = 1'b1;
   // dominant wins on the wire, recessive when both release
   assign rxd = node_q & txd;
   // hold one level for n clocks
   task automatic drive(input logic lvl, input int n);
      node_q <= lvl;
      repeat (n) @(posedge pclk);
   endtask
endmodule

/* File: verification/can_integration_and_intermission_tb.sv */
// self-checking bench for the integration and intermission core
// assumes the peer node model on the bus and a 25 MHz pclk
`timescale 1ns/10ps
`include "cani_regs.svh"
module can_integration_and_intermission_tb import cani_pkg::*;;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, r;
   logic pready, pslverr, rxd, txd, tx_bit_next, e;
   logic tx_req = 1'b0;
   logic tx_first_bit = 1'b1;
   logic tx_bit = 1'b0;
   logic pexc = 1'b0;
   logic frame_done = 1'b0;
   logic crc_check = 1'b0;
   logic fd_frame = 1'b0;
   logic [16:0] rx_crc = 17'h0;
   logic [16:0] crc_fd;
   logic [14:0] crc_classic;
   logic bus_idle, rx_valid, rx_data;
   logic rx_ready = 1'b0;
   logic [3:0] b;
   int fail_count = 0;
   int cmp_count = 0;
   int n;

   cani_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rxd(rxd), .txd(txd), .tx_req(tx_req),
      .tx_first_bit(tx_first_bit), .tx_bit(tx_bit),
      .tx_bit_next(tx_bit_next), .pexc(pexc), .frame_done(frame_done),
      .crc_check(crc_check), .fd_frame(fd_frame), .rx_crc(rx_crc),
      .crc_fd(crc_fd), .crc_classic(crc_classic), .bus_idle(bus_idle),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data));
   cani_peer peer (.pclk(pclk), .txd(txd), .rxd(rxd));

   // 40 ns clock
   initial begin
      forever #20 pclk = ~pclk;
   end

   // verdict and end of run
   task automatic close_out;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // compare and count
   task automatic chk(input string s, input logic [31:0] x,
      input logic [31:0] y);
      cmp_count++;
      if (y !== x) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", s, x, y);
      end
   endtask

   // fd crc of four frame bits, msb first, from the start value
   function automatic logic [16:0] crc17_of(input logic [3:0] v);
      logic [16:0] c;
      c = `CANI_CRC17_INIT;
      for (int i = 3; i >= 0; i--) begin
         c = {c[15:0], 1'b0} ^ ((v[i] ^ c[16]) ? `CANI_CRC17_POLY : 17'h0);
      end
      return c;
   endfunction

   // one apb transfer; read data and error taken at the pready edge
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk("pready", 32'h1, 32'(n < 20));
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // clocks until the bus is reported idle, within a window
   task automatic idle_in(input int lo, input int hi);
      n = 0;
      while (bus_idle !== 1'b1 && n < hi) begin
         @(posedge pclk);
         n++;
      end
      chk("idle time", 32'h1, 32'(n >= lo && n < hi));
   endtask

   // main sequence
   initial begin
      void'($urandom(8186));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `CANI_CTRL_OFF, 32'h0);
      chk("ctrl", `CANI_CTRL_RST, r);
      apb(1'b0, `CANI_NBTR_OFF, 32'h0);
      chk("nbtr", `CANI_NBTR_RST, r);
      apb(1'b0, `CANI_STAT_OFF, 32'h0);
      chk("stat", {26'h0, CANI_OFF}, r);
      apb(1'b0, 12'h00C, 32'h0);
      chk("unmapped", 32'h1, {r[30:0], e});
      // seg2 field 1 gives two quanta: eight-clock bits
      apb(1'b1, `CANI_NBTR_OFF, 32'h0000_0401);
      apb(1'b1, `CANI_CTRL_OFF, 32'h0);
      apb(1'b0, `CANI_STAT_OFF, 32'h0);
      chk("integ", {26'h0, CANI_INTEG}, r);
      // a full dominant bit restarts the recessive count
      peer.drive(1'b0, 8);
      peer.drive(1'b1, 1);
      idle_in(80, 92);
      apb(1'b0, `CANI_STAT_OFF, 32'h0);
      chk("idle", {26'h0, CANI_IDLE}, r);
      // with halt disable a protocol exception stops the controller
      apb(1'b1, `CANI_CTRL_OFF, 32'h2);
      pexc <= 1'b1;
      @(posedge pclk);
      pexc <= 1'b0;
      apb(1'b0, `CANI_CTRL_OFF, 32'h0);
      chk("halt ctrl", 32'h3, r);
      apb(1'b0, `CANI_STAT_OFF, 32'h0);
      chk("halt stat", {26'h0, CANI_OFF}, r);
      // filter on: single-quantum spikes must not delay idle
      apb(1'b1, `CANI_CTRL_OFF, 32'h4);
      repeat (3) begin
         peer.drive(1'b1, 24);
         peer.drive(1'b0, 1);
      end
      peer.drive(1'b1, 1);
      idle_in(2, 30);
      // without halt disable an exception re-integrates
      pexc <= 1'b1;
      @(posedge pclk);
      pexc <= 1'b0;
      apb(1'b0, `CANI_STAT_OFF, 32'h0);
      chk("reinteg", {26'h0, CANI_INTEG}, r);
      idle_in(60, 100);
      // start of frame, then random bits with the receiver stalled
      peer.drive(1'b0, 7);
      chk("crc start", 32'(`CANI_CRC17_INIT), 32'(crc_fd));
      chk("crc classic", 32'(`CANI_CRC15_INIT), 32'(crc_classic));
      peer.drive(1'b0, 1);
      b = 4'($urandom);
      for (int i = 3; i >= 0; i--) peer.drive(b[i], 8);
      chk("crc bits", 32'(crc17_of(b)), 32'(crc_fd));
      apb(1'b0, `CANI_STAT_OFF, 32'h0);
      chk("overrun", 32'h0000_0208, r);
      // drain between samples; two words kept, later ones dropped
      repeat (3) @(posedge pclk);
      rx_ready <= 1'b1;
      for (int i = 3; i >= 2; i--) begin
         @(posedge pclk);
         chk("rx bit", {30'h0, 1'b1, b[i]}, {30'h0, rx_valid, rx_data});
      end
      apb(1'b1, `CANI_STAT_OFF, 32'h0000_0200);
      apb(1'b0, `CANI_STAT_OFF, 32'h0);
      chk("cleared", 32'h8, r);
      // a crc mismatch outside an fd frame is ignored
      rx_crc <= ~crc_fd;
      crc_check <= 1'b1;
      @(posedge pclk);
      crc_check <= 1'b0;
      apb(1'b0, `CANI_STAT_OFF, 32'h0);
      chk("no error", 32'h8, r);
      // fd mismatch at a bit boundary: six dominant bits of error flag
      @(posedge pclk);
      fd_frame <= 1'b1;
      rx_crc <= ~crc_fd;
      crc_check <= 1'b1;
      tx_req <= 1'b1;
      @(posedge pclk);
      crc_check <= 1'b0;
      n = 0;
      while (txd !== 1'b0 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      n = 0;
      while (txd !== 1'b1 && n < 60) begin
         @(posedge pclk);
         n++;
      end
      chk("error flag", 32'd48, n);
      // dominant third intermission bit starts the pending frame
      peer.drive(1'b1, 16);
      peer.drive(1'b0, 6);
      peer.drive(1'b1, 1);
      n = 1;
      e = 1'b0;
      while (txd !== 1'b0 && n < 30) begin
         @(posedge pclk);
         n++;
         e = e | tx_bit_next;
      end
      chk("first id bit", 32'h1, 32'(n >= 8 && n <= 13));
      chk("tx bit taken", 32'h1, {31'h0, e});
      tx_req <= 1'b0;
      frame_done <= 1'b1;
      @(posedge pclk);
      frame_done <= 1'b0;
      idle_in(16, 40);
      close_out();
   end

   // hang guard, about 5000 clocks
   initial begin
      #200000;
      fail_count++;
      close_out();
   end
endmodule
